// ==== hdl/pamux_regs.vh ====
`ifndef PAMUX_REGS_VH
`define PAMUX_REGS_VH
`define PAMUX_ADDR_CPU_CTRL    4'h0
`define PAMUX_ADDR_ALT_CFG     4'h1
`define PAMUX_ADDR_IFACE_CFG   4'h2
`define PAMUX_ADDR_FIFO_POL    4'h3
`define PAMUX_ADDR_WAKE_CTRL   4'h4
`define PAMUX_ADDR_OUT_EN      4'h5
`define PAMUX_ADDR_OUT_DATA    4'h6
`define PAMUX_ADDR_PIN_IN      4'h7
`define PAMUX_ADDR_IRQ_STAT    4'h8
`define PAMUX_ADDR_IRQ_MASK    4'h9
`define PAMUX_ADDR_IRQ_TRIG    4'ha
`define PAMUX_ADDR_STATUS      4'hb
`define PAMUX_CPU_CLK_LO       0
`define PAMUX_CPU_CLK_HI       1
`define PAMUX_CPU_CLOCK_OUTPUT_PIN_TRI   1
`define PAMUX_CPU_CLKSEL_LO    3
`define PAMUX_CPU_CLKSEL_HI    4
`define PAMUX_CPU_CTRL_RST     8'h00
`define PAMUX_CLKSEL_12        2'h0
`define PAMUX_CLKSEL_24        2'h1
`define PAMUX_CLKSEL_48        2'h2
`define PAMUX_FIFO_POL_OE      4
`define PAMUX_WAKE_ENABLE      1
`define PAMUX_WAKE_POLARITY    4
`define PAMUX_WAKE_PINSEL      7
`define PAMUX_WAKE_SUSPEND     0
`define PAMUX_IFACE_PORT       2'h0
`define PAMUX_IFACE_MASTER     2'h2
`define PAMUX_IFACE_FIFO       2'h3
`define PAMUX_IRQ_EXT_IRQ0_N         0
`define PAMUX_IRQ_EXT_IRQ1_N         1
`define PAMUX_IRQ_WAKE         2
`define PAMUX_DIV_12           4'h4
`define PAMUX_DIV_24           4'h2
`define PAMUX_DIV_48           4'h1
`endif

// ==== hdl/pamux_sync.v ====
`timescale 1ns/100ps
// Two-stage synchroniser for pin inputs; the first stage feeds only the second.
// Both stages reset high, the idle level of the pins, so release gives no false edge.
module pamux_sync (
  input  wire       ref_clk,
  input  wire       nrst,
  input  wire [3:0] din,
  output reg  [3:0] dout
);
  reg [3:0] meta_q;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 4'hf;
      dout   <= 4'hf;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ==== hdl/pamux_top.v ====
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "pamux_regs.vh"
// Functional notes
// - Low chip reset clears all internal state; the pin synchroniser and pin history reset to all ones instead.
// - Clock output runs at 12, 24, 48 MHz.
// - Core and clock output default 12 MHz.
// - Control bit 1 set tri-states clock output.
// - Alt config bit 0 picks pin0 interrupt.
// - Interrupt 0 edge when 1, level when 0.
// - Alt bit 1 picks pin1 interrupt 1.
// - Interface bits pick pin2 FIFO output enable.
// - Output enable polarity follows polarity bit 4.
// - Wake bit 7 with output enable bit 3 clear picks pin3.
// - Wake enable bit 1, polarity bit 4.
// - Wake transition in suspend restarts, interrupts.
// - Asserted wake input refuses suspend entry.
// - Interface bits pick port, master, FIFO; master here acts as port mode, only FIFO changes pin use.
module pamux_top (
  input  wire       ref_clk,
  input  wire       nrst,
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output reg        irq,
  output reg        clock_output_pin_o,
  output reg        clock_output_pin_oe,
  output reg  [1:0] core_clk_sel,
  input  wire [3:0] port_a_i,
  output reg  [3:0] port_a_o,
  output reg  [3:0] port_a_oe,
  output reg        fifo_drive_en,
  output reg        osc_restart,
  output reg        suspended
);
  reg  [7:0] cpu_ctrl_q;
  reg  [1:0] alt_cfg_q;
  reg  [1:0] iface_q;
  reg  [7:0] fifo_pol_q;
  reg  [7:0] wake_q;
  reg  [3:0] oe_q;
  reg  [3:0] out_q;
  reg  [2:0] stat_q;
  reg  [2:0] stat_d;
  reg  [2:0] mask_q;
  reg  [1:0] trig_q;
  reg  [3:0] pin_prev_q;
  reg  [3:0] div_cnt_q;
  reg        susp_q;
  reg        refused_q;
  reg  [7:0] rdata_d;
  // Next-state values, one for each register.
  reg  [7:0] cpu_ctrl_d;
  reg  [1:0] alt_cfg_d;
  reg  [1:0] iface_d;
  reg  [7:0] fifo_pol_d;
  reg  [7:0] wake_d;
  reg  [3:0] oe_d;
  reg  [3:0] out_d;
  reg  [2:0] mask_d;
  reg  [1:0] trig_d;
  reg        susp_d;
  reg        refused_d;
  reg  [3:0] div_cnt_d;
  reg        clk_out_d;
  reg        irq_d;
  reg  [3:0] port_oe_d;
  reg        fifo_en_d;
  wire [3:0] pin_s;
  wire [1:0] clk_sel;
  wire       irq0_sel;
  wire       irq1_sel;
  wire       oe_sel;
  wire       wake_sel;
  wire       ext_irq0_n;
  wire       ext_irq1_n;
  wire       irq0_ev;
  wire       irq1_ev;
  wire       wake_asserted;
  wire       wake_edge;
  wire       wake_ev;
  wire [3:0] div_max;
  wire       wr_stat;
  wire       susp_req;
  // One write strobe per writable register address.
  wire       wr_cpu_ctrl;
  wire       wr_alt_cfg;
  wire       wr_iface;
  wire       wr_fifo_pol;
  wire       wr_wake;
  wire       wr_oe;
  wire       wr_out;
  wire       wr_mask;
  wire       wr_trig;

  pamux_sync u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     (port_a_i),
    .dout    (pin_s)
  );

  assign clk_sel    = cpu_ctrl_q[`PAMUX_CPU_CLKSEL_HI:`PAMUX_CPU_CLKSEL_LO];
  assign irq0_sel   = alt_cfg_q[0];
  assign irq1_sel   = alt_cfg_q[1];
  assign oe_sel     = (iface_q == `PAMUX_IFACE_FIFO);
  // Pin 3 is the wake input only when selected and its port driver is off.
  assign wake_sel   = wake_q[`PAMUX_WAKE_PINSEL] & ~oe_q[3];
  assign ext_irq0_n = pin_s[0];
  assign ext_irq1_n = pin_s[1];
  assign irq0_ev = irq0_sel & (trig_q[0] ? (pin_prev_q[0] & ~ext_irq0_n) : ~ext_irq0_n);
  assign irq1_ev = irq1_sel & (trig_q[1] ? (pin_prev_q[1] & ~ext_irq1_n) : ~ext_irq1_n);
  assign wake_asserted = wake_sel & wake_q[`PAMUX_WAKE_ENABLE] &
                         (pin_s[3] == wake_q[`PAMUX_WAKE_POLARITY]);
  assign wake_edge = wake_sel & wake_q[`PAMUX_WAKE_ENABLE] & (pin_s[3] != pin_prev_q[3]);
  assign wake_ev   = susp_q & wake_edge;
  assign div_max   = (clk_sel == `PAMUX_CLKSEL_48) ? `PAMUX_DIV_48 :
                     (clk_sel == `PAMUX_CLKSEL_24) ? `PAMUX_DIV_24 : `PAMUX_DIV_12;
  assign wr_cpu_ctrl = reg_wr & (reg_addr == `PAMUX_ADDR_CPU_CTRL);
  assign wr_alt_cfg  = reg_wr & (reg_addr == `PAMUX_ADDR_ALT_CFG);
  assign wr_iface    = reg_wr & (reg_addr == `PAMUX_ADDR_IFACE_CFG);
  assign wr_fifo_pol = reg_wr & (reg_addr == `PAMUX_ADDR_FIFO_POL);
  assign wr_wake     = reg_wr & (reg_addr == `PAMUX_ADDR_WAKE_CTRL);
  assign wr_oe       = reg_wr & (reg_addr == `PAMUX_ADDR_OUT_EN);
  assign wr_out      = reg_wr & (reg_addr == `PAMUX_ADDR_OUT_DATA);
  assign wr_mask     = reg_wr & (reg_addr == `PAMUX_ADDR_IRQ_MASK);
  assign wr_trig     = reg_wr & (reg_addr == `PAMUX_ADDR_IRQ_TRIG);
  assign wr_stat     = reg_wr & (reg_addr == `PAMUX_ADDR_IRQ_STAT);
  // Bit 0 of the wake control word is a suspend request strobe and is never stored.
  assign susp_req    = wr_wake & reg_wdata[`PAMUX_WAKE_SUSPEND];

  // Each register keeps its value unless its own address is written.
  always @* begin
    cpu_ctrl_d = cpu_ctrl_q;
    alt_cfg_d  = alt_cfg_q;
    iface_d    = iface_q;
    fifo_pol_d = fifo_pol_q;
    wake_d     = wake_q;
    oe_d       = oe_q;
    out_d      = out_q;
    mask_d     = mask_q;
    trig_d     = trig_q;
    if (wr_cpu_ctrl)
      cpu_ctrl_d = reg_wdata;
    if (wr_alt_cfg)
      alt_cfg_d = reg_wdata[1:0];
    if (wr_iface)
      iface_d = reg_wdata[1:0];
    if (wr_fifo_pol)
      fifo_pol_d = reg_wdata;
    if (wr_wake)
      wake_d = {reg_wdata[7:1], 1'b0};
    if (wr_oe)
      oe_d = reg_wdata[3:0];
    if (wr_out)
      out_d = reg_wdata[3:0];
    if (wr_mask)
      mask_d = reg_wdata[2:0];
    if (wr_trig)
      trig_d = reg_wdata[1:0];
  end

  // A held wake level blocks suspend entry; a wake edge ends suspend and wins over a new request.
  always @* begin
    susp_d    = susp_q;
    refused_d = refused_q;
    if (susp_req) begin
      refused_d = wake_asserted;
      if (!wake_asserted)
        susp_d = 1'b1;
    end
    if (wake_ev)
      susp_d = 1'b0;
  end

  // A rate change takes effect at the next count limit, within one output half period.
  always @* begin
    div_cnt_d = div_cnt_q + 4'h1;
    clk_out_d = clock_output_pin_o;
    if (div_cnt_q >= div_max - 4'h1) begin
      div_cnt_d = 4'h0;
      clk_out_d = ~clock_output_pin_o;
    end
  end

  // Alternate functions are input only, so their port drivers stay off while selected.
  always @* begin
    port_oe_d = oe_q & ~{1'b0, oe_sel, irq1_sel, irq0_sel};
    fifo_en_d = oe_sel & (pin_s[2] == fifo_pol_q[`PAMUX_FIFO_POL_OE]);
    irq_d     = |(stat_d & mask_q);
  end

  always @* begin
    // New events win over a write-one-to-clear in the same cycle.
    stat_d = stat_q;
    if (wr_stat)
      stat_d = stat_d & ~reg_wdata[2:0];
    stat_d = stat_d | {wake_ev, irq1_ev, irq0_ev};
  end

  always @* begin
    case (reg_addr)
      `PAMUX_ADDR_CPU_CTRL:  rdata_d = cpu_ctrl_q;
      `PAMUX_ADDR_ALT_CFG:   rdata_d = {6'h00, alt_cfg_q};
      `PAMUX_ADDR_IFACE_CFG: rdata_d = {6'h00, iface_q};
      `PAMUX_ADDR_FIFO_POL:  rdata_d = fifo_pol_q;
      `PAMUX_ADDR_WAKE_CTRL: rdata_d = {wake_q[7:1], susp_q};
      `PAMUX_ADDR_OUT_EN:    rdata_d = {4'h0, oe_q};
      `PAMUX_ADDR_OUT_DATA:  rdata_d = {4'h0, out_q};
      `PAMUX_ADDR_PIN_IN:    rdata_d = {4'h0, pin_s};
      `PAMUX_ADDR_IRQ_STAT:  rdata_d = {5'h00, stat_q};
      `PAMUX_ADDR_IRQ_MASK:  rdata_d = {5'h00, mask_q};
      `PAMUX_ADDR_IRQ_TRIG:  rdata_d = {6'h00, trig_q};
      `PAMUX_ADDR_STATUS:    rdata_d = {5'h00, refused_q, wake_asserted, susp_q};
      default:               rdata_d = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_ctrl_q <= `PAMUX_CPU_CTRL_RST;
      alt_cfg_q  <= 2'h0;
      iface_q    <= `PAMUX_IFACE_PORT;
      fifo_pol_q <= 8'h00;
      wake_q     <= 8'h00;
      oe_q       <= 4'h0;
      out_q      <= 4'h0;
      mask_q     <= 3'h0;
      trig_q     <= 2'h0;
    end else begin
      cpu_ctrl_q <= cpu_ctrl_d;
      alt_cfg_q  <= alt_cfg_d;
      iface_q    <= iface_d;
      fifo_pol_q <= fifo_pol_d;
      wake_q     <= wake_d;
      oe_q       <= oe_d;
      out_q      <= out_d;
      mask_q     <= mask_d;
      trig_q     <= trig_d;
    end
  end

  // The pin history resets to the idle high level that the synchroniser also starts from.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stat_q     <= 3'h0;
      pin_prev_q <= 4'hf;
      susp_q     <= 1'b0;
      refused_q  <= 1'b0;
    end else begin
      stat_q     <= stat_d;
      pin_prev_q <= pin_s;
      susp_q     <= susp_d;
      refused_q  <= refused_d;
    end
  end

  // Read data stand in the cycle after each cycle of reg_rd and read as zero otherwise.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
    end
  end

  // Clock output divider; the output toggles every div_max cycles of the 96 MHz clock.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_q           <= 4'h0;
      clock_output_pin_o  <= 1'b0;
      clock_output_pin_oe <= 1'b0;
      core_clk_sel        <= `PAMUX_CLKSEL_12;
    end else begin
      core_clk_sel        <= clk_sel;
      clock_output_pin_oe <= ~cpu_ctrl_q[`PAMUX_CPU_CLOCK_OUTPUT_PIN_TRI];
      div_cnt_q           <= div_cnt_d;
      clock_output_pin_o  <= clk_out_d;
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      port_a_o      <= 4'h0;
      port_a_oe     <= 4'h0;
      fifo_drive_en <= 1'b0;
      osc_restart   <= 1'b0;
      irq           <= 1'b0;
      suspended     <= 1'b0;
    end else begin
      port_a_o      <= out_q;
      port_a_oe     <= port_oe_d;
      fifo_drive_en <= fifo_en_d;
      osc_restart   <= wake_ev;
      irq           <= irq_d;
      suspended     <= susp_d;
    end
  end
endmodule

// ==== bench/pamux_props.sv ====
`timescale 1ns/100ps
module pamux_props (
  input wire       ref_clk,
  input wire       nrst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       irq,
  input wire       clock_output_pin_o,
  input wire       clock_output_pin_oe,
  input wire [1:0] core_clk_sel,
  input wire [3:0] port_a_oe,
  input wire       fifo_drive_en,
  input wire       osc_restart
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  rst_clear_a: assert property (disable iff (1'b0) !nrst |-> port_a_oe == 4'h0 && !irq)
    else $error("outputs active in reset");
  rst_default_a: assert property ($rose(nrst) |-> core_clk_sel == 2'h0 && port_a_oe == 4'h0)
    else $error("bad state after reset");
  div_slow_a: assert property ($changed(clock_output_pin_o) && core_clk_sel == 2'h0 |=>
    ($stable(clock_output_pin_o) || core_clk_sel != 2'h0) [*3]) else $error("slow clock too fast");
  div_fast_a: assert property ($changed(clock_output_pin_o) && core_clk_sel == 2'h2 |=>
    $changed(clock_output_pin_o) || core_clk_sel != 2'h2) else $error("fast clock too slow");
  clk_tristate_a: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[1] |->
    ##[1:3] !clock_output_pin_oe) else $error("clock output still driven");
  pin_drive_a: assert property (reg_wr && reg_addr == 4'h5 && reg_wdata[3] |-> ##[1:2] port_a_oe[3])
    else $error("pin3 driver not enabled");
  fifo_input_a: assert property (fifo_drive_en |-> !port_a_oe[2])
    else $error("fifo enable pin driven");
  wake_pulse_a: assert property (osc_restart |=> !osc_restart)
    else $error("restart pulse too long");
endmodule
bind pamux_top pamux_props u_props (
  .ref_clk             (ref_clk),
  .nrst                (nrst),
  .reg_addr            (reg_addr),
  .reg_wdata           (reg_wdata),
  .reg_wr              (reg_wr),
  .irq                 (irq),
  .clock_output_pin_o  (clock_output_pin_o),
  .clock_output_pin_oe (clock_output_pin_oe),
  .core_clk_sel        (core_clk_sel),
  .port_a_oe           (port_a_oe),
  .fifo_drive_en       (fifo_drive_en),
  .osc_restart         (osc_restart)
);

// ==== bench/pamux_host.sv ====
`timescale 1ns/100ps
// Far-side master: holds every pin that the device has released.
module pamux_host (
  input  wire [3:0] drv,
  input  wire [3:0] dev_o,
  input  wire [3:0] dev_oe,
  output wire [3:0] pin
);
  assign pin = (dev_oe & dev_o) | (~dev_oe & drv);
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  logic        ref_clk = 0;
  logic        nrst;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic [3:0]  reg_addr = 4'h0;
  logic [3:0]  drv = 4'hf;
  logic [7:0]  reg_wdata = 8'h00;
  wire  [7:0]  reg_rdata;
  wire  [3:0]  port_a_i, port_a_o, port_a_oe;
  wire  [1:0]  core_clk_sel;
  wire         irq, clock_output_pin_o, clock_output_pin_oe, fifo_drive_en, osc_restart, suspended;
  int          fail_count = 0;
  int          compares = 0;
  int          i;
  // Control write, far-side pin levels, expected clock select, expected clock drive.
  logic [14:0] rows [4] = '{{8'h00, 4'ha, 2'h0, 1'b1}, {8'h08, 4'h5, 2'h1, 1'b1},
                            {8'h02, 4'h6, 2'h0, 1'b0}, {8'h10, 4'hf, 2'h2, 1'b1}};
  pamux_top dut_u (
    .ref_clk             (ref_clk),
    .nrst                (nrst),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .irq                 (irq),
    .clock_output_pin_o  (clock_output_pin_o),
    .clock_output_pin_oe (clock_output_pin_oe),
    .core_clk_sel        (core_clk_sel),
    .port_a_i            (port_a_i),
    .port_a_o            (port_a_o),
    .port_a_oe           (port_a_oe),
    .fifo_drive_en       (fifo_drive_en),
    .osc_restart         (osc_restart),
    .suspended           (suspended)
  );
  pamux_host host_u (.drv(drv), .dev_o(port_a_o), .dev_oe(port_a_oe), .pin(port_a_i));
  initial forever #5 ref_clk = ~ref_clk;
  task chk(input logic [7:0] e, input logic [7:0] s, input string n);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(e, reg_rdata, n);
  endtask
  // Pin levels pass two synchroniser stages before any effect, so allow five cycles.
  task pins(input logic [3:0] v);
    @(posedge ref_clk);
    drv <= v;
    repeat (5) @(negedge ref_clk);
  endtask
  task print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    // Driving reset from unknown to low makes a falling edge, so the design resets at time zero.
    nrst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    pins(4'hf);
    chk(8'h00, {6'h0, core_clk_sel}, "reset select");
    rd(4'h7, 8'h0f, "reset pins");
    for (i = 0; i < 4; i++) begin
      wr(4'h0, rows[i][14:7]);
      pins(rows[i][6:3]);
      chk({6'h0, rows[i][2:1]}, {6'h0, core_clk_sel}, "clock select");
      chk({7'h0, rows[i][0]}, {7'h0, clock_output_pin_oe}, "clock drive");
      rd(4'h7, {4'h0, rows[i][6:3]}, "pin levels");
    end
    wr(4'h1, 8'h03);
    wr(4'ha, 8'h03);
    wr(4'h9, 8'h01);
    wr(4'h8, 8'h07);
    pins(4'he);
    chk(8'h01, {7'h0, irq}, "edge irq");
    pins(4'hf);
    rd(4'h8, 8'h01, "edge status");
    wr(4'h8, 8'h01);
    pins(4'hd);
    chk(8'h00, {7'h0, irq}, "masked irq");
    pins(4'hf);
    rd(4'h8, 8'h02, "irq1 status");
    wr(4'ha, 8'h00);
    wr(4'h8, 8'h02);
    pins(4'he);
    rd(4'h8, 8'h01, "level status");
    pins(4'hf);
    wr(4'h8, 8'h01);
    rd(4'h8, 8'h00, "level cleared");
    wr(4'h2, 8'h03);
    pins(4'hb);
    chk(8'h01, {7'h0, fifo_drive_en}, "fifo oe low");
    wr(4'h3, 8'h10);
    pins(4'hf);
    chk(8'h01, {7'h0, fifo_drive_en}, "fifo oe high");
    wr(4'h2, 8'h00);
    pins(4'hf);
    chk(8'h00, {7'h0, fifo_drive_en}, "port mode");
    wr(4'h6, 8'h08);
    wr(4'h5, 8'h08);
    pins(4'h7);
    rd(4'h7, 8'h0f, "driven pin");
    wr(4'h5, 8'h00);
    wr(4'h4, 8'h92);
    pins(4'hf);
    wr(4'h4, 8'h93);
    rd(4'hb, 8'h06, "suspend refused");
    pins(4'h7);
    wr(4'h4, 8'h93);
    rd(4'hb, 8'h01, "suspended");
    chk(8'h01, {7'h0, suspended}, "suspended pin");
    @(posedge ref_clk);
    drv <= 4'hf;
    for (i = 0; i < 20 && osc_restart !== 1'b1; i++) @(negedge ref_clk);
    chk(8'h01, {7'h0, osc_restart}, "restart");
    chk(8'h00, {7'h0, suspended}, "suspend ended");
    rd(4'h8, 8'h04, "wake status");
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(negedge ref_clk);
    chk(8'h00, {6'h0, core_clk_sel}, "reset select");
    @(posedge ref_clk);
    nrst <= 1'b1;
    rd(4'h8, 8'h00, "status after reset");
    print_verdict;
  end
endmodule
